// [logic/smc_pkg.sv]
// smc_pkg: constants and types for the sleep mode controller
package smc_pkg;
  // sleep kind codes
  localparam logic [2:0] KIND_IDLE = 3'h0;
  localparam logic [2:0] KIND_ADC_NR = 3'h1;
  localparam logic [2:0] KIND_PDOWN = 3'h2;
  localparam logic [2:0] KIND_PSAVE = 3'h3;
  localparam logic [2:0] KIND_STBY = 3'h6;
  localparam logic [2:0] KIND_XSTBY = 3'h7;
  // timing, in cycles of the system clock
  localparam int STBY_WAKE_CYC = 6;
  localparam int IRQ_HOLD_CYC = 4;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] STBY_WAKE_CNT = CNT_W'(STBY_WAKE_CYC);
  localparam logic [CNT_W-1:0] IRQ_HOLD_CNT = CNT_W'(IRQ_HOLD_CYC);

  typedef enum logic [2:0] {
    SMC_RUN, SMC_SLEEP, SMC_START, SMC_HOLD
  } smc_state_t;

  // clock and oscillator gates, one means running
  typedef struct packed {
    logic cpu_clock;
    logic flash_clock;
    logic io_clock;
    logic converter_clock;
    logic timer_xtal_clock;
    logic main_osc;
    logic timer_osc;
    logic sync_t2_only;
  } smc_gates_t;

  // wake sources presented by the interrupt and reset logic
  typedef struct packed {
    logic any_irq;
    logic ext_pin_irq_a;
    logic ext_pin_irq_b;
    logic pin_a_level;
    logic pin_b_level;
    logic pin_change_irq;
    logic two_wire_port;
    logic timer2_irq;
    logic self_program;
    logic conv_done;
    logic watchdog_irq;
  } smc_wake_t;
endpackage : smc_pkg

// [logic/smc_top.sv]
// smc_top: sleep mode controller with clock gating and wake-up sequencing
// How it works
// [RQ1] sleep entered only when sleep enable is set and sleep instruction runs
// [RQ2] idle stops cpu and flash clocks, others keep running; the code also stops the timer oscillator unless timer 2 is asynchronous
// [RQ3] idle wakes on any enabled interrupt
// [RQ4] converter noise mode halts io, cpu and flash clocks
// [RQ5] entering converter noise mode with converter enabled starts conversion
// [RQ6] converter noise mode wakes only on its listed sources
// [RQ7] timer 2 counts in converter noise mode only on async clock
// [RQ8] power-down stops main oscillator and all generated clocks
// [RQ9] power-down wakes only on watchdog, two-wire match, level or pin change
// [RQ10] outside idle, pin interrupts wake only when set as level
// [RQ11] level wake with level gone wakes without interrupt
// [RQ12] power-down wake waits the reset time-out period
// [RQ13] power-save like power-down, timer 2 wakes if enabled and global enable
// [RQ14] power-save stops timer oscillator or main source per timer 2 clocking
// [RQ15] standby keeps main oscillator running when crystal selected
// [RQ16] standby resumes six cycles after wake
// [RQ17] extended standby is power-save with main oscillator running; the code keeps the main oscillator running only when crystal selected
// [RQ18] extended standby resumes six cycles after wake
// [RQ19] interrupt wake holds cpu four cycles beyond start-up
// [RQ20] no memory is touched, contents survive sleep
// [RQ21] any reset during sleep wakes to the reset vector
// [RQ22] sleep instruction with enable clear is a no-operation
`timescale 1ns/100ps
module smc_top (
  // clock and reset
  input wire logic CLK,
  input wire logic NRST,
  // cpu side
  input wire logic SLEEP_INSN,
  input wire logic SLEEP_ENABLE,
  input wire logic [2:0] SLEEP_KIND_CODE,
  input wire logic GLOBAL_IRQ_EN,
  input wire logic [1:0] TIMER2_IRQ_MASK,
  // configuration
  input wire logic CRYSTAL_SEL,
  input wire logic CONV_ENABLED,
  input wire logic T2_ASYNC,
  input wire logic T2_SYNC,
  input wire logic [15:0] STARTUP_CYCLES,
  // wake and reset sources
  input wire smc_pkg::smc_wake_t WAKE,
  input wire logic SYS_RESET_REQ,
  // outputs
  output smc_pkg::smc_gates_t GATES,
  output logic CPU_HALT,
  output logic CONV_START,
  output logic IRQ_TAKE,
  output logic RESET_VECTOR,
  output logic ASLEEP
);
  smc_pkg::smc_state_t state_r, state_nxt;
  logic [2:0] kind_r;
  logic [15:0] cnt_r, cnt_nxt;
  logic irq_pend_r, irq_pend_nxt;
  smc_pkg::smc_gates_t gates_nxt;
  logic conv_start_nxt, halt_nxt;

  // ----------------------------------------------------------------
  // wake decode
  // ----------------------------------------------------------------
  wire enter = SLEEP_INSN && SLEEP_ENABLE; // RQ1 RQ22
  // codes outside the six modes leave the cpu running
  wire kind_ok = SLEEP_KIND_CODE inside {smc_pkg::KIND_IDLE, smc_pkg::KIND_ADC_NR,
                 smc_pkg::KIND_PDOWN, smc_pkg::KIND_PSAVE, smc_pkg::KIND_STBY,
                 smc_pkg::KIND_XSTBY};
  wire k_idle = kind_r == smc_pkg::KIND_IDLE;
  wire k_adc = kind_r == smc_pkg::KIND_ADC_NR;
  wire k_save = kind_r == smc_pkg::KIND_PSAVE;
  wire k_stby = kind_r == smc_pkg::KIND_STBY;
  wire k_xstby = kind_r == smc_pkg::KIND_XSTBY;
  wire lvl_a = WAKE.ext_pin_irq_a && WAKE.pin_a_level; // RQ10
  wire lvl_b = WAKE.ext_pin_irq_b && WAKE.pin_b_level; // RQ10
  wire async_src = lvl_a || lvl_b || WAKE.pin_change_irq || WAKE.two_wire_port
                   || WAKE.watchdog_irq; // RQ9
  wire t2_wake = WAKE.timer2_irq && (|TIMER2_IRQ_MASK) && GLOBAL_IRQ_EN; // RQ13
  wire adc_src = async_src || WAKE.conv_done || WAKE.self_program
                 || (WAKE.timer2_irq && T2_ASYNC); // RQ6 RQ7
  wire wake_ev = k_idle ? WAKE.any_irq : // RQ3
                 k_adc ? adc_src :
                 (k_save || k_xstby) ? (async_src || t2_wake) : async_src;
  // irq is only delivered if the source still stands at end of start-up
  wire src_irq = wake_ev && !(k_idle && !WAKE.any_irq);
  wire fast_wake = k_stby || k_xstby || k_idle || k_adc; // RQ16 RQ18
  wire [15:0] start_len = fast_wake ? smc_pkg::STBY_WAKE_CNT : STARTUP_CYCLES; // RQ12

  // ----------------------------------------------------------------
  // clock gating per mode
  // ----------------------------------------------------------------
  function automatic smc_pkg::smc_gates_t sleep_gates(input logic [2:0] k, input logic xtal,
      input logic t2a, input logic t2s);
    smc_pkg::smc_gates_t g;
    g = '0;
    case (k)
      smc_pkg::KIND_IDLE: begin // RQ2
        g.io_clock = 1'b1;
        g.converter_clock = 1'b1;
        g.timer_xtal_clock = 1'b1;
        g.main_osc = 1'b1;
        g.timer_osc = t2a;
      end
      smc_pkg::KIND_ADC_NR: begin // RQ4 RQ7
        g.converter_clock = 1'b1;
        g.timer_xtal_clock = t2a;
        g.main_osc = 1'b1;
        g.timer_osc = t2a;
      end
      smc_pkg::KIND_PSAVE: begin // RQ13 RQ14
        g.timer_xtal_clock = t2a;
        g.timer_osc = t2a;
        g.main_osc = t2s;
        g.sync_t2_only = t2s;
      end
      smc_pkg::KIND_STBY: begin // RQ15
        g.main_osc = xtal;
      end
      smc_pkg::KIND_XSTBY: begin // RQ17
        g.timer_xtal_clock = t2a;
        g.timer_osc = t2a;
        g.main_osc = xtal;
        g.sync_t2_only = t2s;
      end
      default: g = '0; // RQ8 power-down
    endcase
    return g;
  endfunction : sleep_gates

  // awake: every clock runs, the timer-only sync path is not in use
  localparam smc_pkg::smc_gates_t ALL_ON = '{sync_t2_only: 1'b0, default: 1'b1};

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    irq_pend_nxt = irq_pend_r;
    gates_nxt = GATES;
    conv_start_nxt = 1'b0;
    halt_nxt = CPU_HALT;
    case (state_r)
      smc_pkg::SMC_RUN: begin
        gates_nxt = ALL_ON;
        halt_nxt = 1'b0;
        if (enter && kind_ok) begin // RQ1
          state_nxt = smc_pkg::SMC_SLEEP;
          gates_nxt = sleep_gates(SLEEP_KIND_CODE, CRYSTAL_SEL, T2_ASYNC, T2_SYNC);
          halt_nxt = 1'b1;
          conv_start_nxt = (SLEEP_KIND_CODE == smc_pkg::KIND_ADC_NR) && CONV_ENABLED; // RQ5
        end
      end
      smc_pkg::SMC_SLEEP: begin
        if (wake_ev) begin
          state_nxt = smc_pkg::SMC_START;
          cnt_nxt = start_len;
          gates_nxt = ALL_ON;
        end
      end
      smc_pkg::SMC_START: begin
        if (cnt_r <= smc_pkg::CNT_ONE) begin
          irq_pend_nxt = src_irq; // RQ11
          if (src_irq) begin
            state_nxt = smc_pkg::SMC_HOLD;
            cnt_nxt = smc_pkg::IRQ_HOLD_CNT; // RQ19
          end else begin
            state_nxt = smc_pkg::SMC_RUN;
            halt_nxt = 1'b0;
          end
        end else begin
          cnt_nxt = cnt_r - smc_pkg::CNT_ONE;
        end
      end
      smc_pkg::SMC_HOLD: begin
        if (cnt_r <= smc_pkg::CNT_ONE) begin
          state_nxt = smc_pkg::SMC_RUN;
          halt_nxt = 1'b0;
        end else begin
          cnt_nxt = cnt_r - smc_pkg::CNT_ONE;
        end
      end
      default: state_nxt = smc_pkg::SMC_RUN;
    endcase
    // reset request overrides all but the conversion start and restarts in run, pulsing the vector only when not already in run
    if (SYS_RESET_REQ) begin // RQ21
      state_nxt = smc_pkg::SMC_RUN;
      gates_nxt = ALL_ON;
      halt_nxt = 1'b0;
      irq_pend_nxt = 1'b0;
      cnt_nxt = smc_pkg::CNT_ZERO;
    end
  end

  // no memory is reset or written here, so contents survive sleep  RQ20
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= smc_pkg::SMC_RUN;
      kind_r <= smc_pkg::KIND_IDLE;
      cnt_r <= smc_pkg::CNT_ZERO;
      irq_pend_r <= 1'b0;
      GATES <= ALL_ON;
      CPU_HALT <= 1'b0;
      CONV_START <= 1'b0;
      IRQ_TAKE <= 1'b0;
      RESET_VECTOR <= 1'b0;
      ASLEEP <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == smc_pkg::SMC_RUN && enter)
        kind_r <= SLEEP_KIND_CODE;
      cnt_r <= cnt_nxt;
      irq_pend_r <= irq_pend_nxt;
      GATES <= gates_nxt;
      CPU_HALT <= halt_nxt;
      CONV_START <= conv_start_nxt;
      IRQ_TAKE <= (state_r == smc_pkg::SMC_HOLD) && (state_nxt == smc_pkg::SMC_RUN)
                  && irq_pend_r; // RQ19
      RESET_VECTOR <= SYS_RESET_REQ && (state_r != smc_pkg::SMC_RUN); // RQ21
      ASLEEP <= state_nxt == smc_pkg::SMC_SLEEP;
    end
  end

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // start-up length counted apart from cnt_r, so the length check does not lean on it
  logic [15:0] start_seen_r;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      start_seen_r <= smc_pkg::CNT_ZERO;
    end else if (state_r == smc_pkg::SMC_START) begin
      start_seen_r <= start_seen_r + smc_pkg::CNT_ONE;
    end else begin
      start_seen_r <= smc_pkg::CNT_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_nop_no_sleep: assert property (@(posedge CLK) disable iff (!NRST) // RQ22
    (state_r == smc_pkg::SMC_RUN && SLEEP_INSN && !SLEEP_ENABLE && !SYS_RESET_REQ)
    |=> state_r == smc_pkg::SMC_RUN) else $error("sleep taken with enable clear");
  chk_idle_gates: assert property (@(posedge CLK) disable iff (!NRST) // RQ2
    (state_r == smc_pkg::SMC_SLEEP && k_idle) |-> (!GATES.cpu_clock && GATES.io_clock))
    else $error("idle gating wrong");
  chk_adc_gates: assert property (@(posedge CLK) disable iff (!NRST) // RQ4
    (state_r == smc_pkg::SMC_SLEEP && k_adc) |-> (!GATES.io_clock && GATES.converter_clock))
    else $error("converter noise gating wrong");
  chk_pdown_gates: assert property (@(posedge CLK) disable iff (!NRST) // RQ8
    (state_r == smc_pkg::SMC_SLEEP && kind_r == smc_pkg::KIND_PDOWN) |-> GATES == '0)
    else $error("power-down clocks running");
  chk_conv_start: assert property (@(posedge CLK) disable iff (!NRST) // RQ5
    (state_r == smc_pkg::SMC_RUN && enter && SLEEP_KIND_CODE == smc_pkg::KIND_ADC_NR
     && CONV_ENABLED && !SYS_RESET_REQ) |=> CONV_START) else $error("no conversion start");
  chk_stby_six: assert property (@(posedge CLK) disable iff (!NRST) // RQ16
    (state_r == smc_pkg::SMC_SLEEP && k_stby && wake_ev && !SYS_RESET_REQ)
    ##1 (!SYS_RESET_REQ)[*6]
    |-> state_r == smc_pkg::SMC_START ##1 state_r != smc_pkg::SMC_START)
    else $error("standby wake not six cycles");
  chk_xstby_six: assert property (@(posedge CLK) disable iff (!NRST) // RQ18
    (state_r == smc_pkg::SMC_SLEEP && k_xstby && wake_ev && !SYS_RESET_REQ)
    ##1 (!SYS_RESET_REQ)[*6]
    |-> state_r == smc_pkg::SMC_START ##1 state_r != smc_pkg::SMC_START)
    else $error("extended standby wake not six cycles");
  chk_pdown_len: assert property (@(posedge CLK) disable iff (!NRST) // RQ12
    (state_r == smc_pkg::SMC_START && state_nxt != smc_pkg::SMC_START && !SYS_RESET_REQ
     && (kind_r == smc_pkg::KIND_PDOWN || k_save) && STARTUP_CYCLES > smc_pkg::CNT_ONE)
    |-> start_seen_r == STARTUP_CYCLES - smc_pkg::CNT_ONE)
    else $error("power-down start-up length wrong");
  chk_hold_four: assert property (@(posedge CLK) disable iff (!NRST) // RQ19
    ($rose(state_r == smc_pkg::SMC_HOLD)) ##1 (!SYS_RESET_REQ)[*3]
    |-> state_r == smc_pkg::SMC_HOLD ##1 state_r == smc_pkg::SMC_RUN)
    else $error("interrupt hold not four cycles");
  chk_reset_vec: assert property (@(posedge CLK) disable iff (!NRST) // RQ21
    (SYS_RESET_REQ && state_r == smc_pkg::SMC_SLEEP) |=> (RESET_VECTOR && !CPU_HALT))
    else $error("reset during sleep not taken");
  chk_edge_ignored: assert property (@(posedge CLK) disable iff (!NRST) // RQ10
    (state_r == smc_pkg::SMC_SLEEP && kind_r == smc_pkg::KIND_PDOWN && !SYS_RESET_REQ
     && !WAKE.pin_change_irq && !WAKE.two_wire_port && !WAKE.watchdog_irq
     && !(WAKE.ext_pin_irq_a && WAKE.pin_a_level) && !(WAKE.ext_pin_irq_b && WAKE.pin_b_level))
    |=> state_r == smc_pkg::SMC_SLEEP) else $error("edge irq woke device");
  chk_psave_gates: assert property (@(posedge CLK) disable iff (!NRST) // RQ14
    (state_r == smc_pkg::SMC_SLEEP && k_save) |-> (GATES.timer_osc == T2_ASYNC
     && GATES.main_osc == T2_SYNC && GATES.sync_t2_only == T2_SYNC && !GATES.io_clock))
    else $error("power-save oscillators wrong");
  chk_stby_osc: assert property (@(posedge CLK) disable iff (!NRST) // RQ15
    (state_r == smc_pkg::SMC_SLEEP && k_stby) |-> (GATES.main_osc == CRYSTAL_SEL
     && !GATES.io_clock && !GATES.timer_osc)) else $error("standby oscillator wrong");
  chk_xstby_osc: assert property (@(posedge CLK) disable iff (!NRST) // RQ17
    (state_r == smc_pkg::SMC_SLEEP && k_xstby) |-> (GATES.main_osc == CRYSTAL_SEL
     && GATES.timer_osc == T2_ASYNC && !GATES.io_clock))
    else $error("extended standby oscillator wrong");
  chk_adc_timer: assert property (@(posedge CLK) disable iff (!NRST) // RQ7
    (state_r == smc_pkg::SMC_SLEEP && k_adc) |-> GATES.timer_xtal_clock == T2_ASYNC)
    else $error("timer 2 clock wrong in converter noise mode");
  chk_pdown_wake: assert property (@(posedge CLK) disable iff (!NRST) // RQ9
    (state_r == smc_pkg::SMC_SLEEP && kind_r == smc_pkg::KIND_PDOWN && !SYS_RESET_REQ
     && (WAKE.pin_change_irq || WAKE.two_wire_port || WAKE.watchdog_irq))
    |=> state_r == smc_pkg::SMC_START) else $error("power-down source did not wake");
  chk_adc_wake: assert property (@(posedge CLK) disable iff (!NRST) // RQ6
    (state_r == smc_pkg::SMC_SLEEP && k_adc && !SYS_RESET_REQ
     && (WAKE.conv_done || WAKE.self_program)) |=> state_r == smc_pkg::SMC_START)
    else $error("converter noise source did not wake");
  chk_idle_wake: assert property (@(posedge CLK) disable iff (!NRST) // RQ3
    (state_r == smc_pkg::SMC_SLEEP && k_idle && !SYS_RESET_REQ && WAKE.any_irq)
    |=> state_r == smc_pkg::SMC_START) else $error("idle interrupt did not wake");
  chk_t2_wake: assert property (@(posedge CLK) disable iff (!NRST) // RQ13
    (state_r == smc_pkg::SMC_SLEEP && (k_save || k_xstby) && !SYS_RESET_REQ
     && WAKE.timer2_irq && GLOBAL_IRQ_EN && (|TIMER2_IRQ_MASK)) |=> state_r == smc_pkg::SMC_START)
    else $error("timer 2 did not wake power-save");
  chk_level_lost: assert property (@(posedge CLK) disable iff (!NRST) // RQ11
    (state_r == smc_pkg::SMC_START && cnt_r <= smc_pkg::CNT_ONE && !wake_ev && !SYS_RESET_REQ)
    |=> (state_r == smc_pkg::SMC_RUN && !CPU_HALT && !IRQ_TAKE))
    else $error("lost level still raised interrupt");
  cov_idle_wake: cover property (@(posedge CLK) state_r == smc_pkg::SMC_SLEEP && k_idle
    ##1 state_r == smc_pkg::SMC_START);
  cov_pdown_wake: cover property (@(posedge CLK) state_r == smc_pkg::SMC_SLEEP
    && kind_r == smc_pkg::KIND_PDOWN ##1 state_r == smc_pkg::SMC_START);
  cov_irq_take: cover property (@(posedge CLK) IRQ_TAKE);
  cov_reset_sleep: cover property (@(posedge CLK) RESET_VECTOR);
  cov_level_lost: cover property (@(posedge CLK) state_r == smc_pkg::SMC_START
    && cnt_r <= smc_pkg::CNT_ONE && !wake_ev);
endmodule : smc_top

// [testbench/smc_src_model.sv]
// smc_src_model: wake source model holding a level pattern for a set time
`timescale 1ns/100ps
module smc_src_model (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // request
  input wire logic fire,
  input smc_pkg::smc_wake_t pat,
  input wire logic [15:0] hold,
  // wake levels
  output smc_pkg::smc_wake_t wake
);
  logic [15:0] cnt_r;
  smc_pkg::smc_wake_t pat_r;
  // source keeps its level for hold cycles, then lets go
  assign wake = (cnt_r != 16'h0000) ? pat_r : smc_pkg::smc_wake_t'(11'h000);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 16'h0000;
      pat_r <= smc_pkg::smc_wake_t'(11'h000);
    end else if (fire) begin
      cnt_r <= hold;
      pat_r <= pat;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
endmodule : smc_src_model

// [testbench/testbench.sv]
// testbench: sleep entry, gating and wake timing of the sleep controller
`timescale 1ns/100ps
module testbench;
  logic CLK = 0, NRST = 0, SLEEP_INSN = 0, SLEEP_ENABLE = 0, GLOBAL_IRQ_EN = 1;
  logic CRYSTAL_SEL = 0, CONV_ENABLED = 0, T2_ASYNC = 0, T2_SYNC = 0;
  logic SYS_RESET_REQ = 0, fire = 0;
  logic [2:0] SLEEP_KIND_CODE = 3'h0;
  logic [1:0] TIMER2_IRQ_MASK = 2'h3;
  logic [15:0] STARTUP_CYCLES = 16'h0014, hold = 16'h0000;
  smc_pkg::smc_wake_t pat = smc_pkg::smc_wake_t'(11'h000), WAKE;
  smc_pkg::smc_gates_t GATES;
  logic CPU_HALT, CONV_START, IRQ_TAKE, RESET_VECTOR, ASLEEP;
  int fail_count = 0, total_checks = 0;
  always #5 CLK = ~CLK;
  smc_top smc_top_i (.CLK(CLK), .NRST(NRST), .SLEEP_INSN(SLEEP_INSN),
    .SLEEP_ENABLE(SLEEP_ENABLE), .SLEEP_KIND_CODE(SLEEP_KIND_CODE),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .TIMER2_IRQ_MASK(TIMER2_IRQ_MASK),
    .CRYSTAL_SEL(CRYSTAL_SEL), .CONV_ENABLED(CONV_ENABLED), .T2_ASYNC(T2_ASYNC),
    .T2_SYNC(T2_SYNC), .STARTUP_CYCLES(STARTUP_CYCLES), .WAKE(WAKE),
    .SYS_RESET_REQ(SYS_RESET_REQ), .GATES(GATES), .CPU_HALT(CPU_HALT),
    .CONV_START(CONV_START), .IRQ_TAKE(IRQ_TAKE), .RESET_VECTOR(RESET_VECTOR),
    .ASLEEP(ASLEEP));
  smc_src_model smc_src_model_i (.clk(CLK), .nrst(NRST), .fire(fire), .pat(pat),
    .hold(hold), .wake(WAKE));
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task step;
    @(posedge CLK);
    #1;
  endtask : step
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task sleep(input logic [2:0] code, input logic en);
    SLEEP_KIND_CODE = code;
    SLEEP_ENABLE = en;
    SLEEP_INSN = 1;
    step;
    SLEEP_INSN = 0;
  endtask : sleep
  task fire_src(input logic [10:0] p, input int h);
    pat = smc_pkg::smc_wake_t'(p);
    hold = h[15:0];
    fire = 1;
    step;
    fire = 0;
  endtask : fire_src
  // n below zero: cycle count not checked
  task wake(input logic [10:0] p, input int h, input int n, input logic irq);
    int c;
    logic seen;
    fire_src(p, h);
    c = 0;
    while (ASLEEP !== 1'b0 && c < 50) begin step; c++; end
    chk("asleep_drop", 16'h0000, {15'h0000, ASLEEP});
    chk("gates_wake", 16'h000f, {12'h000, GATES.cpu_clock, GATES.flash_clock,
      GATES.io_clock, GATES.converter_clock});
    c = 0;
    seen = 0;
    while (CPU_HALT !== 1'b0 && c < 300) begin step; c++; seen |= IRQ_TAKE; end
    chk("halt_drop", 16'h0000, {15'h0000, CPU_HALT});
    chk("irq_take", {15'h0000, irq}, {15'h0000, seen});
    if (n >= 0) chk("wake_cycles", n[15:0], c[15:0]);
    repeat (8) step;
  endtask : wake
  task ignored(input logic [10:0] p);
    fire_src(p, 5);
    repeat (8) step;
    chk("stay_asleep", 16'h0001, {15'h0000, ASLEEP});
  endtask : ignored
  task close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) step;
    NRST = 1;
    step;
    sleep(smc_pkg::KIND_IDLE, 0);
    step;
    chk("asleep_noop", 16'h0000, {15'h0000, ASLEEP});
    sleep(3'h4, 1);
    step;
    chk("asleep_rsvd", 16'h0000, {15'h0000, ASLEEP});
    sleep(smc_pkg::KIND_IDLE, 1);
    chk("asleep_idle", 16'h0001, {15'h0000, ASLEEP});
    chk("gates_idle", 16'h0003, {12'h000, GATES.cpu_clock, GATES.flash_clock,
      GATES.io_clock, GATES.converter_clock});
    wake(11'h400, 14, 10, 1);
    CONV_ENABLED = 1;
    sleep(smc_pkg::KIND_ADC_NR, 1);
    chk("conv_start", 16'h0001, {15'h0000, CONV_START});
    chk("gates_adc", 16'h0002, {11'h000, GATES.cpu_clock, GATES.flash_clock,
      GATES.io_clock, GATES.converter_clock, GATES.timer_xtal_clock});
    ignored(11'h208);
    wake(11'h002, 14, 10, 1);
    CONV_ENABLED = 0;
    sleep(smc_pkg::KIND_PDOWN, 1);
    chk("gates_pdown", 16'h0000, {12'h000, GATES.cpu_clock, GATES.io_clock,
      GATES.converter_clock, GATES.main_osc});
    ignored(11'h108);
    wake(11'h020, 28, 24, 1);
    sleep(smc_pkg::KIND_PDOWN, 1);
    wake(11'h280, 2, -1, 0);
    T2_ASYNC = 1;
    sleep(smc_pkg::KIND_PSAVE, 1);
    chk("osc_psave", 16'h0001, {14'h0000, GATES.main_osc, GATES.timer_osc});
    wake(11'h008, 28, 24, 1);
    GLOBAL_IRQ_EN = 0;
    T2_ASYNC = 0;
    T2_SYNC = 1;
    sleep(smc_pkg::KIND_PSAVE, 1);
    chk("osc_psave_sync", 16'h0005, {13'h0000, GATES.main_osc, GATES.timer_osc,
      GATES.sync_t2_only});
    ignored(11'h008);
    SYS_RESET_REQ = 1;
    step;
    chk("reset_vector", 16'h0001, {15'h0000, RESET_VECTOR});
    chk("halt_reset", 16'h0000, {15'h0000, CPU_HALT});
    SYS_RESET_REQ = 0;
    GLOBAL_IRQ_EN = 1;
    T2_SYNC = 0;
    CRYSTAL_SEL = 1;
    repeat (3) step;
    sleep(smc_pkg::KIND_STBY, 1);
    chk("osc_stby", 16'h0001, {14'h0000, GATES.io_clock, GATES.main_osc});
    ignored(11'h008);
    wake(11'h011, 14, 10, 1);
    sleep(smc_pkg::KIND_XSTBY, 1);
    chk("osc_xstby", 16'h0001, {14'h0000, GATES.io_clock, GATES.main_osc});
    wake(11'h008, 14, 10, 1);
    close_out;
  end
endmodule : testbench
